// ==== dtif_bus_master.sv ====
// Serial bus master model for the tag front end
`timescale 1ns/10ps
module dtif_bus_master (
    // Clock
    input wire logic clk,
    // Bus lines
    input wire logic sda,
    output logic scl,
    output logic sda_oe
);
    initial begin
        scl = 1'b1;
        sda_oe = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    // Phases of 8 clk keep every edge well clear of the synchroniser delay
    task automatic start_cond();
        sda_oe <= 1'b0;
        tick(8);
        scl <= 1'b1;
        tick(8);
        sda_oe <= 1'b1;
        tick(8);
        scl <= 1'b0;
        tick(8);
    endtask

    task automatic stop_cond();
        sda_oe <= 1'b1;
        tick(8);
        scl <= 1'b1;
        tick(8);
        sda_oe <= 1'b0;
        tick(8);
    endtask

    // Data is set mid low phase and sampled mid high phase
    task automatic bit_slot(input logic pull, output logic seen);
        sda_oe <= pull;
        tick(8);
        scl <= 1'b1;
        tick(4);
        seen = sda;
        tick(4);
        scl <= 1'b0;
        tick(8);
    endtask

    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_slot(~b[i], s);
        end
        bit_slot(1'b0, s);
        ack = ~s;
    endtask

    task automatic recv_byte(input logic ack, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_slot(1'b0, s);
            b[i] = s;
        end
        bit_slot(ack, s);
    endtask
endmodule // dtif_bus_master

// ==== dtif_front.sv ====
// Dual-interface tag front end: serial slave, memory, contactless coding, indication pin
`timescale 1ns/10ps
`include "dtif_map.svh"
module dtif_front import dtif_pkg::*; #(
    parameter int DEPTH = 2048,
    parameter logic [3:0] DEV_TYPE = 4'hB, // Arbitrary value
    parameter logic CHIP_EN = 1'b0
) (
    // System clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Serial bus pins
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    // Contactless block port, system clock
    input wire dtif_blk_req_t blk_req_i,
    output logic [31:0] blk_rdata_o,
    // Indication pin and configuration
    input wire dtif_ind_mode_t ind_mode_i,
    input wire logic vcc_ok_i,
    output logic activity_pin_o,
    output logic activity_pin_oe,
    // Energy harvesting
    input wire logic harvest_enable_i,
    input wire logic field_ok_i,
    output logic harvest_oe,
    // Contactless link clock domain
    input wire logic rf_clk,
    input wire logic rf_write_busy_i,
    input wire logic rf_cmd_busy_i,
    input wire logic rx_pause_i,
    input wire dtif_rx_ctl_t rx_ctl_i,
    output logic [7:0] rx_data_o,
    output logic rx_valid_o,
    input wire dtif_tx_cfg_t tx_cfg_i,
    input wire logic tx_valid_i,
    input wire logic tx_bit_i,
    output logic tx_ready_o,
    output logic load_mod_o
);
    localparam int AW = $clog2(DEPTH);

    // System clock side synchronisers
    logic [5:0] sys_sync;
    logic scl_s, sda_s, vcc_s, field_s, wbusy_s, cbusy_s;

    dtif_sync #(.W(6)) u_sys_sync (
        .clk(clk),
        .rst_n(resetn),
        .d({scl_i, sda_i, vcc_ok_i, field_ok_i, rf_write_busy_i, rf_cmd_busy_i}),
        .q(sys_sync)
    );
    assign {scl_s, sda_s, vcc_s, field_s, wbusy_s, cbusy_s} = sys_sync;

    // Bus edge detection, sampled on the system clock
    logic scl_p_q, sda_p_q;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            // Matches the synchroniser reset level, so no false Start or Stop follows reset
            scl_p_q <= 1'b0;
            sda_p_q <= 1'b0;
        end else begin
            scl_p_q <= scl_s;
            sda_p_q <= sda_s;
        end
    end

    wire scl_rise = scl_s & ~scl_p_q;
    wire scl_fall = ~scl_s & scl_p_q;
    wire start_det = scl_s & scl_p_q & sda_p_q & ~sda_s;
    wire stop_det = scl_s & scl_p_q & ~sda_p_q & sda_s;

    // Serial slave state
    dtif_i2c_st_t st_q;
    logic [3:0] bit_q;
    logic [7:0] shift_q;
    logic [1:0] byte_q;
    logic rw_q;
    logic [15:0] addr_q;
    logic sda_oe_q;
    logic [7:0] mem_q [DEPTH];

    wire [AW-1:0] mem_idx = addr_q[AW-1:0];
    wire [7:0] rd_byte = mem_q[mem_idx];
    wire sel_match = (shift_q[7:4] == DEV_TYPE) && (shift_q[3] == CHIP_EN)
        && (shift_q[2:1] == `DTIF_SEL_FIXED);
    wire byte_done = (st_q == ST_RX) && scl_fall && (bit_q == `DTIF_BYTE_BITS);
    wire sel_done = byte_done && (byte_q == `DTIF_IDX_SEL);
    wire i2c_we = byte_done && (byte_q == `DTIF_IDX_DATA) && !rw_q;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_q <= ST_IDLE;
            bit_q <= '0;
            shift_q <= '0;
            byte_q <= '0;
            rw_q <= 1'b0;
            addr_q <= '0;
            sda_oe_q <= 1'b0;
        end else if (start_det) begin
            // A Start always resynchronises, also out of the ignore state
            st_q <= ST_RX;
            bit_q <= '0;
            byte_q <= `DTIF_IDX_SEL;
            sda_oe_q <= 1'b0;
        end else if (stop_det) begin
            st_q <= ST_IDLE;
            sda_oe_q <= 1'b0;
        end else begin
            unique case (st_q)
                ST_IDLE, ST_IGNORE: begin
                    sda_oe_q <= 1'b0;
                end
                ST_RX: begin
                    if (scl_rise && bit_q != `DTIF_BYTE_BITS) begin
                        shift_q <= {shift_q[6:0], sda_s};
                        bit_q <= bit_q + 4'h1;
                    end else if (byte_done) begin
                        bit_q <= '0;
                        if (sel_done && !sel_match) begin
                            st_q <= ST_IGNORE;
                        end else begin
                            st_q <= ST_ACK;
                            sda_oe_q <= 1'b1;
                            if (byte_q != `DTIF_IDX_DATA) begin
                                byte_q <= byte_q + 2'h1;
                            end
                            if (byte_q == `DTIF_IDX_SEL) begin
                                rw_q <= shift_q[0];
                            end
                            if (byte_q == `DTIF_IDX_ADDR_HI) begin
                                addr_q[15:8] <= shift_q;
                            end
                            if (byte_q == `DTIF_IDX_ADDR_LO) begin
                                addr_q[7:0] <= shift_q;
                            end
                            if (i2c_we) begin
                                addr_q <= addr_q + 16'h0001;
                            end
                        end
                    end
                end
                ST_ACK, ST_RDGO: begin
                    if (scl_fall) begin
                        bit_q <= '0;
                        if (rw_q) begin
                            st_q <= ST_TX;
                            shift_q <= rd_byte;
                            sda_oe_q <= ~rd_byte[7];
                        end else begin
                            st_q <= ST_RX;
                            sda_oe_q <= 1'b0;
                        end
                    end
                end
                ST_TX: begin
                    if (scl_fall) begin
                        bit_q <= bit_q + 4'h1;
                        if (bit_q == `DTIF_TX_LAST_BIT) begin
                            st_q <= ST_MACK;
                            sda_oe_q <= 1'b0;
                            addr_q <= addr_q + 16'h0001;
                        end else begin
                            shift_q <= {shift_q[6:0], 1'b0};
                            sda_oe_q <= ~shift_q[6];
                        end
                    end
                end
                ST_MACK: begin
                    // No acknowledge ends the read; only Stop or Start follow
                    if (scl_rise) begin
                        st_q <= sda_s ? ST_IGNORE : ST_RDGO;
                    end
                end
            endcase
        end
    end

    assign sda_o = 1'b0;
    assign sda_oe = sda_oe_q;

    // Shared byte store, a contactless word write wins over a serial byte write
    generate
        for (genvar i = 0; i < DEPTH; i++) begin : g_mem
            wire blk_hit = blk_req_i.we && (blk_req_i.addr == 9'(i / 4));
            wire ser_hit = i2c_we && (mem_idx == AW'(i));
            always_ff @(posedge clk or negedge resetn) begin
                if (!resetn) begin
                    mem_q[i] <= `DTIF_MEM_INIT;
                end else if (blk_hit) begin
                    mem_q[i] <= blk_req_i.wdata[8 * (i % 4) +: 8];
                end else if (ser_hit) begin
                    mem_q[i] <= shift_q;
                end
            end
        end
    endgenerate

    // Word view, lowest byte address in the low bits
    logic [31:0] blk_rdata_q;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            blk_rdata_q <= '0;
        end else begin
            blk_rdata_q <= {mem_q[{blk_req_i.addr, 2'h3}], mem_q[{blk_req_i.addr, 2'h2}],
                mem_q[{blk_req_i.addr, 2'h1}], mem_q[{blk_req_i.addr, 2'h0}]};
        end
    end
    assign blk_rdata_o = blk_rdata_q;

    // Indication pin and harvest enable
    logic pin_oe_q, harvest_q;
    wire ind_src = (ind_mode_i == DTIF_IND_WRITE) ? wbusy_s : cbusy_s;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pin_oe_q <= 1'b0;
            harvest_q <= 1'b0;
        end else begin
            pin_oe_q <= vcc_s & ind_src;
            harvest_q <= harvest_enable_i & field_s;
        end
    end
    assign activity_pin_o = 1'b0;
    assign activity_pin_oe = pin_oe_q;
    assign harvest_oe = harvest_q;

    // Link domain reset release and pause synchroniser
    logic rf_rst_n, pause_s, pause_p_q;
    dtif_sync #(.W(1)) u_rf_rst (
        .clk(rf_clk),
        .rst_n(resetn),
        .d(1'b1),
        .q(rf_rst_n)
    );
    dtif_sync #(.W(1)) u_rf_pause (
        .clk(rf_clk),
        .rst_n(rf_rst_n),
        .d(rx_pause_i),
        .q(pause_s)
    );

    // Downlink pulse position decoder, one slot is 256 carrier cycles
    logic rx_act_q, seen_q, rx_valid_q;
    logic [7:0] fc_q, slot_q, pos_q, rx_data_q;
    wire slot_end = fc_q == `DTIF_SLOT_LAST;
    wire [7:0] last_slot = rx_ctl_i.one_of_four ? `DTIF_LAST_SLOT_1OF4 : `DTIF_LAST_SLOT_1OF256;
    wire sym_end = rx_act_q && slot_end && (slot_q == last_slot);
    wire pause_rise = pause_s & ~pause_p_q;

    always_ff @(posedge rf_clk or negedge rf_rst_n) begin
        if (!rf_rst_n) begin
            pause_p_q <= 1'b0;
            rx_act_q <= 1'b0;
            seen_q <= 1'b0;
            fc_q <= '0;
            slot_q <= '0;
            pos_q <= '0;
        end else begin
            pause_p_q <= pause_s;
            if (rx_ctl_i.sof) begin
                rx_act_q <= 1'b1;
                seen_q <= 1'b0;
                fc_q <= '0;
                slot_q <= '0;
            end else if (rx_ctl_i.eof) begin
                rx_act_q <= 1'b0;
            end else if (rx_act_q) begin
                fc_q <= fc_q + 8'h01;
                if (slot_end) begin
                    slot_q <= sym_end ? 8'h00 : slot_q + 8'h01;
                end
                if (sym_end) begin
                    seen_q <= 1'b0;
                end else if (pause_rise && !seen_q) begin
                    seen_q <= 1'b1;
                    pos_q <= slot_q;
                end
            end
        end
    end

    always_ff @(posedge rf_clk or negedge rf_rst_n) begin
        if (!rf_rst_n) begin
            rx_valid_q <= 1'b0;
            rx_data_q <= '0;
        end else begin
            rx_valid_q <= sym_end && seen_q;
            if (sym_end && seen_q) begin
                rx_data_q <= pos_q;
            end
        end
    end
    assign rx_valid_o = rx_valid_q;
    assign rx_data_o = rx_data_q;

    // Uplink Manchester encoder
    logic tx_busy_q, tx_bit_q, ph_q, mod_q;
    logic [11:0] bt_q;
    logic [4:0] sc_q;
    wire fast_mode = tx_cfg_i.fast && tx_cfg_i.high_rate;
    wire use_two = tx_cfg_i.two_sub && !fast_mode;
    wire [11:0] bit_len = fast_mode ? `DTIF_BIT_FAST
        : (tx_cfg_i.high_rate ? `DTIF_BIT_HIGH : `DTIF_BIT_LOW);
    wire in_second = bt_q >= {1'b0, bit_len[11:1]};
    wire bit_end = tx_busy_q && (bt_q == bit_len - 12'h001);
    // Two subcarriers: a zero starts on 423 kHz, a one on 484 kHz
    wire sel_423 = use_two ? ~(tx_bit_q ^ in_second) : 1'b1;
    wire modulate = use_two | (tx_bit_q ? in_second : ~in_second);
    wire [4:0] sc_half = sel_423 ? `DTIF_SC_HALF_423 : `DTIF_SC_HALF_484;
    wire sc_end = sc_q >= sc_half - 5'h01;

    assign tx_ready_o = ~tx_busy_q | bit_end;

    always_ff @(posedge rf_clk or negedge rf_rst_n) begin
        if (!rf_rst_n) begin
            tx_busy_q <= 1'b0;
            tx_bit_q <= 1'b0;
            bt_q <= '0;
            sc_q <= '0;
            ph_q <= 1'b0;
        end else if (tx_ready_o) begin
            tx_busy_q <= tx_valid_i;
            tx_bit_q <= tx_bit_i;
            bt_q <= '0;
            sc_q <= '0;
            ph_q <= 1'b0;
        end else begin
            bt_q <= bt_q + 12'h001;
            sc_q <= sc_end ? 5'h00 : sc_q + 5'h01;
            if (sc_end) begin
                ph_q <= ~ph_q;
            end
        end
    end

    always_ff @(posedge rf_clk or negedge rf_rst_n) begin
        if (!rf_rst_n) begin
            mod_q <= 1'b0;
        end else begin
            mod_q <= tx_busy_q & modulate & ph_q;
        end
    end
    assign load_mod_o = mod_q;

    // Checks, system clock
    AST_MISMATCH_IGNORE: assert property (@(posedge clk) disable iff (!resetn)
        (sel_done && !sel_match && !start_det && !stop_det) |=> st_q == ST_IGNORE)
        else $error("Select mismatch did not enter ignore");
    AST_IGNORE_RELEASED: assert property (@(posedge clk) disable iff (!resetn)
        (st_q == ST_IGNORE) |-> !sda_oe)
        else $error("Data driven while ignoring");
    AST_WRITE_ACK: assert property (@(posedge clk) disable iff (!resetn)
        (byte_done && !rw_q && (byte_q != `DTIF_IDX_SEL) && !start_det && !stop_det)
        |=> sda_oe && st_q == ST_ACK)
        else $error("Written byte not acknowledged");
    AST_MACK_RELEASED: assert property (@(posedge clk) disable iff (!resetn)
        (st_q == ST_MACK) |-> !sda_oe)
        else $error("Data driven in master acknowledge slot");
    AST_NOACK_ENDS: assert property (@(posedge clk) disable iff (!resetn)
        (st_q == ST_MACK && scl_rise && sda_s && !start_det && !stop_det)
        |=> st_q == ST_IGNORE ##1 !sda_oe)
        else $error("Read continued after no acknowledge");
    AST_PIN_SUPPLY: assert property (@(posedge clk) disable iff (!resetn)
        !vcc_s |=> !activity_pin_oe)
        else $error("Indication without supply");
    AST_PIN_WRITE: assert property (@(posedge clk) disable iff (!resetn)
        (vcc_s && wbusy_s && ind_mode_i == DTIF_IND_WRITE) |=> activity_pin_oe)
        else $error("Write indication missing");
    AST_PIN_CMD: assert property (@(posedge clk) disable iff (!resetn)
        (vcc_s && ind_mode_i == DTIF_IND_CMD) |=> activity_pin_oe == $past(cbusy_s))
        else $error("Command indication wrong");
    AST_HARVEST_OFF: assert property (@(posedge clk) disable iff (!resetn)
        (!harvest_enable_i || !field_s) |=> !harvest_oe)
        else $error("Harvest output active while off");
    AST_BLK_WRITE: assert property (@(posedge clk) disable iff (!resetn)
        blk_req_i.we ##1 (!blk_req_i.we && blk_req_i.addr == $past(blk_req_i.addr))
        |=> blk_rdata_o == $past(blk_req_i.wdata, 2))
        else $error("Word write not seen in byte store");

    // Checks, link clock
    AST_FAST_ONE_SUB: assert property (@(posedge rf_clk) disable iff (!rf_rst_n)
        (tx_busy_q && fast_mode) |-> sel_423 && bit_len == `DTIF_BIT_FAST)
        else $error("Fast uplink not on single subcarrier");
    AST_RX_QUARTER: assert property (@(posedge rf_clk) disable iff (!rf_rst_n)
        (rx_valid_o && rx_ctl_i.one_of_four) |-> rx_data_o[7:2] == 6'h00)
        else $error("Quarter coding decoded out of range");

    CVR_READ_SELECT: cover property (@(posedge clk) disable iff (!resetn)
        sel_done && sel_match && shift_q[0]);
    CVR_DATA_WRITE: cover property (@(posedge clk) disable iff (!resetn) i2c_we);
    CVR_PIN_LOW: cover property (@(posedge clk) disable iff (!resetn) $rose(activity_pin_oe));
    CVR_RX_SYMBOL: cover property (@(posedge rf_clk) disable iff (!rf_rst_n) rx_valid_o);
endmodule // dtif_front

// ==== dtif_map.svh ====
// Constant map for the dual-interface tag front end
`ifndef DTIF_MAP_SVH
`define DTIF_MAP_SVH

// Select byte layout and per-byte bit counts
`define DTIF_SEL_FIXED 2'h3
`define DTIF_BYTE_BITS 4'h8
`define DTIF_TX_LAST_BIT 4'h7
// Byte index within a transfer: select, address high, address low, data
`define DTIF_IDX_SEL 2'h0
`define DTIF_IDX_ADDR_HI 2'h1
`define DTIF_IDX_ADDR_LO 2'h2
`define DTIF_IDX_DATA 2'h3
`define DTIF_MEM_INIT 8'hFF
// Downlink pulse position timing, in carrier cycles and slots
`define DTIF_SLOT_LAST 8'hFF
`define DTIF_LAST_SLOT_1OF4 8'h03
`define DTIF_LAST_SLOT_1OF256 8'hFF
// Uplink bit times in carrier cycles
`define DTIF_BIT_LOW 12'h0800
`define DTIF_BIT_HIGH 12'h0200
`define DTIF_BIT_FAST 12'h0100
// Subcarrier half periods in carrier cycles
`define DTIF_SC_HALF_423 5'h10
`define DTIF_SC_HALF_484 5'h0E

`endif

// ==== dtif_pkg.sv ====
// Types shared by the dual-interface tag front end
package dtif_pkg;

    typedef enum logic {
        DTIF_IND_WRITE,
        DTIF_IND_CMD
    } dtif_ind_mode_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RX,
        ST_ACK,
        ST_TX,
        ST_MACK,
        ST_RDGO,
        ST_IGNORE
    } dtif_i2c_st_t;

    typedef struct packed {
        logic we;
        logic [8:0] addr;
        logic [31:0] wdata;
    } dtif_blk_req_t;

    typedef struct packed {
        logic sof;
        logic eof;
        logic one_of_four;
    } dtif_rx_ctl_t;

    typedef struct packed {
        logic high_rate;
        logic two_sub;
        logic fast;
    } dtif_tx_cfg_t;

endpackage

// ==== dtif_sync.sv ====
// Two-flop level synchroniser
`timescale 1ns/10ps
module dtif_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Levels
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= '0;
            q <= '0;
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule // dtif_sync

// ==== tb_top.sv ====
// Self-checking bench for the tag front end
`timescale 1ns/10ps
module tb_top import dtif_pkg::*;;
    localparam logic [3:0] DEV_ID = 4'hB; // Arbitrary value
    localparam logic [7:0] SEL_W = {DEV_ID, 4'h6};
    localparam logic [7:0] SEL_R = {DEV_ID, 4'h7};
    logic clk, resetn, rf_clk, scl, sda, m_oe, sda_o, sda_oe;
    logic vcc_ok_i, act_o, act_oe, harv_en, field_ok, harvest_oe;
    logic wbusy, cbusy, pause, rx_valid_o, tx_valid_i, tx_bit_i, tx_ready_o, load_mod_o;
    logic [31:0] blk_rdata_o;
    logic [7:0] rx_data_o;
    dtif_blk_req_t blk_req_i;
    dtif_ind_mode_t ind_mode_i;
    dtif_rx_ctl_t rx_ctl_i;
    dtif_tx_cfg_t tx_cfg_i;
    int bad_count = 0;
    int tests_run = 0;

    // Open-drain line with pull-up
    assign sda = (sda_oe | m_oe) ? 1'b0 : 1'b1;

    dtif_front #(.DEV_TYPE(DEV_ID), .CHIP_EN(1'b0)) dtif_front_i (
        .clk(clk), .resetn(resetn), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
        .sda_oe(sda_oe), .blk_req_i(blk_req_i), .blk_rdata_o(blk_rdata_o),
        .ind_mode_i(ind_mode_i), .vcc_ok_i(vcc_ok_i), .activity_pin_o(act_o),
        .activity_pin_oe(act_oe), .harvest_enable_i(harv_en), .field_ok_i(field_ok),
        .harvest_oe(harvest_oe), .rf_clk(rf_clk), .rf_write_busy_i(wbusy),
        .rf_cmd_busy_i(cbusy), .rx_pause_i(pause), .rx_ctl_i(rx_ctl_i),
        .rx_data_o(rx_data_o), .rx_valid_o(rx_valid_o), .tx_cfg_i(tx_cfg_i),
        .tx_valid_i(tx_valid_i), .tx_bit_i(tx_bit_i), .tx_ready_o(tx_ready_o),
        .load_mod_o(load_mod_o));

    dtif_bus_master dtif_bus_master_i (.clk(clk), .sda(sda), .scl(scl), .sda_oe(m_oe));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        rf_clk = 1'b0;
        #7;
        forever #24 rf_clk = ~rf_clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict();
        $display("comparisons %0d, mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask

    task automatic point(input logic [15:0] addr);
        logic a;
        dtif_bus_master_i.start_cond();
        dtif_bus_master_i.send_byte(SEL_W, a);
        check(32'(a), 32'h0000_0001);
        dtif_bus_master_i.send_byte(addr[15:8], a);
        dtif_bus_master_i.send_byte(addr[7:0], a);
    endtask

    task automatic read_one(input logic [7:0] exp);
        logic a;
        logic [7:0] d;
        dtif_bus_master_i.start_cond();
        dtif_bus_master_i.send_byte(SEL_R, a);
        dtif_bus_master_i.recv_byte(1'b0, d);
        check(32'(d), 32'(exp));
        dtif_bus_master_i.stop_cond();
    endtask

    // Two bytes written across the top of memory, read back through a repeated Start
    task automatic test_serial_rw();
        logic a;
        logic [7:0] d;
        point(16'h07FF);
        dtif_bus_master_i.send_byte(8'hA5, a);
        dtif_bus_master_i.send_byte(8'h3C, a);
        check(32'(a), 32'h0000_0001);
        dtif_bus_master_i.stop_cond();
        point(16'h07FF);
        dtif_bus_master_i.start_cond();
        dtif_bus_master_i.send_byte(SEL_R, a);
        dtif_bus_master_i.recv_byte(1'b1, d);
        check(32'(d), 32'h0000_00A5);
        dtif_bus_master_i.recv_byte(1'b0, d);
        check(32'(d), 32'h0000_003C);
        dtif_bus_master_i.stop_cond();
    endtask

    task automatic test_refuse();
        logic a;
        logic [7:0] bad [3];
        bad = '{{DEV_ID ^ 4'h1, 4'h6}, {DEV_ID, 4'hE}, {DEV_ID, 4'h2}};
        for (int i = 0; i < 3; i++) begin
            dtif_bus_master_i.start_cond();
            dtif_bus_master_i.send_byte(bad[i], a);
            check(32'(a), 32'h0000_0000);
            dtif_bus_master_i.send_byte(8'h00, a);
            check(32'(a), 32'h0000_0000);
            dtif_bus_master_i.stop_cond();
        end
    endtask

    // Word side sees serial bytes, serial side sees word writes
    task automatic test_block();
        @(posedge clk) blk_req_i <= '{1'b1, 9'h005, 32'h1122_3344};
        @(posedge clk) blk_req_i <= '{1'b0, 9'h005, 32'h0000_0000};
        settle(1);
        check(blk_rdata_o, 32'h1122_3344);
        @(posedge clk) blk_req_i <= '{1'b0, 9'h1FF, 32'h0000_0000};
        settle(1);
        check(32'(blk_rdata_o[31:24]), 32'h0000_00A5);
        @(posedge clk) blk_req_i <= '{1'b0, 9'h000, 32'h0000_0000};
        settle(1);
        check(32'(blk_rdata_o[7:0]), 32'h0000_003C);
        point(16'h0015);
        read_one(8'h33);
    endtask

    task automatic set_ind(input logic v, input logic wb, input logic cb);
        @(posedge rf_clk);
        wbusy <= wb;
        cbusy <= cb;
        vcc_ok_i <= v;
        settle(6);
    endtask

    task automatic test_indicate();
        for (int k = 0; k < 2; k++) begin
            @(posedge clk) ind_mode_i <= dtif_ind_mode_t'(k);
            set_ind(1'b1, 1'b1, 1'b0);
            check(32'(act_oe), 32'(k == 0));
            set_ind(1'b1, 1'b0, 1'b1);
            check(32'(act_oe), 32'(k == 1));
            set_ind(1'b0, 1'b1, 1'b1);
            check(32'(act_oe), 32'h0000_0000);
            check(32'(act_o), 32'h0000_0000);
        end
    endtask

    task automatic test_harvest();
        for (int k = 0; k < 4; k++) begin
            @(posedge clk);
            harv_en <= k[0];
            field_ok <= k[1];
            settle(5);
            check(32'(harvest_oe), 32'(k == 3));
        end
    endtask

    // Pause placed in slot 1, then slot 3, of a 1-of-4 symbol
    task automatic test_down();
        int n;
        for (int s = 1; s < 4; s += 2) begin
            @(posedge rf_clk) rx_ctl_i <= '{1'b1, 1'b0, 1'b1};
            @(posedge rf_clk) rx_ctl_i <= '{1'b0, 1'b0, 1'b1};
            repeat (s * 256 + 20) @(posedge rf_clk);
            pause <= 1'b1;
            repeat (4) @(posedge rf_clk);
            pause <= 1'b0;
            n = 0;
            do begin
                @(negedge rf_clk);
                n++;
            end while (rx_valid_o !== 1'b1 && n < 1100);
            check(32'(rx_valid_o), 32'h0000_0001);
            check(32'(rx_data_o), 32'(s));
            @(posedge rf_clk) rx_ctl_i <= '{1'b0, 1'b1, 1'b1};
            @(posedge rf_clk) rx_ctl_i <= '{1'b0, 1'b0, 1'b1};
        end
    endtask

    // Subcarrier duty counted in each half of a bit, away from its edges
    task automatic test_up();
        int hi_a;
        int hi_b;
        int len;
        int n;
        for (int k = 0; k < 2; k++) begin
            len = k ? 256 : 512;
            @(posedge rf_clk);
            tx_cfg_i <= '{1'b1, 1'b0, k[0]};
            tx_bit_i <= k[0];
            tx_valid_i <= 1'b1;
            n = 0;
            do begin
                @(negedge rf_clk);
                n++;
            end while (tx_ready_o !== 1'b1 && n < 3000);
            @(posedge rf_clk) tx_valid_i <= 1'b0;
            hi_a = 0;
            hi_b = 0;
            for (int c = 1; c <= len; c++) begin
                @(negedge rf_clk);
                if (c >= 8 && c < len / 2 - 24) hi_a += int'(load_mod_o === 1'b1);
                if (c >= len / 2 + 8 && c < len - 24) hi_b += int'(load_mod_o === 1'b1);
            end
            check(32'(hi_a), 32'(k ? 0 : (len / 2 - 32) / 2));
            check(32'(hi_b), 32'(k ? (len / 2 - 32) / 2 : 0));
        end
    endtask

    initial begin
        resetn = 1'b0;
        blk_req_i = '0;
        ind_mode_i = DTIF_IND_WRITE;
        {vcc_ok_i, harv_en, field_ok, wbusy, cbusy, pause} = '0;
        rx_ctl_i = '0;
        tx_cfg_i = '0;
        {tx_valid_i, tx_bit_i} = '0;
        repeat (8) @(posedge clk);
        repeat (3) @(posedge rf_clk);
        @(posedge clk) resetn <= 1'b1;
        repeat (3) @(posedge rf_clk);
        @(posedge clk);
        test_serial_rw();
        test_refuse();
        test_block();
        test_indicate();
        test_harvest();
        test_down();
        test_up();
        print_verdict();
    end

    // Whole run needs about 40k clk
    initial begin
        repeat (90000) @(posedge clk);
        bad_count++;
        print_verdict();
    end
endmodule // tb_top
